// >>> cfsb_defs.svh
// constants for the status flags and data memory region block
`ifndef CFSB_DEFS_SVH
`define CFSB_DEFS_SVH
`define CFSB_DATA_W       8
`define CFSB_ADDR_W       12
`define CFSB_PTR_W        16
`define CFSB_OFS_MSB      6
`define CFSB_BANK_LSB     7
`define CFSB_BANK_MSB     11
`define CFSB_OFS_STATUS   7'h03
`define CFSB_CORE_LAST    7'h0B
`define CFSB_SFR_FIRST    7'h0C
`define CFSB_SFR_LAST     7'h1F
`define CFSB_GPR_FIRST    7'h20
`define CFSB_GPR_BYTES    16'h0050
`define CFSB_COMMON_FIRST 7'h70
`define CFSB_COMMON_BYTES 16
`define CFSB_LINEAR_BASE  16'h2000
`define CFSB_LINEAR_SEL   3'h1
`define CFSB_RST_TO_N     1'b1
`define CFSB_RST_PD_N     1'b1
`define CFSB_RST_ARITH    1'b0
`define CFSB_UNIMPL_BITS  3'h0
`endif

// >>> cfsb_pkg.sv
// types shared by the status flags and data memory region block
`default_nettype none
`include "cfsb_defs.svh"
package cfsb_pkg;
  // instruction classes seen by the status logic
  typedef enum logic [3:0] {
    op_none, op_add, op_sub, op_and, op_or, op_xor, op_move, op_clear,
    op_swap, op_store, op_bit_clear, op_bit_set, op_rot_right, op_rot_left,
    op_watchdog_clear, op_sleep
  } cfsb_op_e;
  // data memory regions, one-hot
  typedef enum logic [5:0] {
    rgn_unimpl = 6'h01,
    rgn_core   = 6'h02,
    rgn_sfr    = 6'h04,
    rgn_gpr    = 6'h08,
    rgn_common = 6'h10,
    rgn_linear = 6'h20
  } cfsb_region_e;
  // status register bits held by the block
  typedef struct packed {
    logic watchdog_timeout_flag_n;
    logic powerdown_flag_n;
    logic zero_flag;
    logic nibble_carry_flag;
    logic carry_flag;
  } cfsb_status_s;
  // one instruction as issued by the execution path
  typedef struct packed {
    logic                     valid;
    cfsb_op_e                 op;
    logic [`CFSB_PTR_W-1:0]   addr;
    logic                     use_literal;
    logic [`CFSB_DATA_W-1:0]  literal;
    logic [`CFSB_DATA_W-1:0]  accum;
    logic [2:0]               bit_idx;
    logic                     dest_file;
  } cfsb_req_s;
  // alu result with computed flags and which flags the op affects
  typedef struct packed {
    logic [`CFSB_DATA_W-1:0] result;
    logic                    zero;
    logic                    nibble_carry;
    logic                    carry;
    logic [2:0]              affect;
  } cfsb_flags_s;
endpackage : cfsb_pkg
`default_nettype wire

// >>> cfsb_alu_flags.sv
// result and flag computation for one instruction
`default_nettype none
`include "cfsb_defs.svh"
module cfsb_alu_flags (
  // operation and operands
  input  wire cfsb_pkg::cfsb_op_e         op,
  input  wire logic [`CFSB_DATA_W-1:0]    accum,
  input  wire logic [`CFSB_DATA_W-1:0]    file_val,
  input  wire logic [2:0]                 bit_idx,
  input  wire logic                       carry_in,
  // result
  output cfsb_pkg::cfsb_flags_s           flags
);
  import cfsb_pkg::*;

  // 8-bit add returning {carry, nibble carry, sum}
  function automatic logic [9:0] add_carries(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction : add_carries

  logic [9:0] sum;

  // result, flags and affect mask per op
  always_comb begin
    sum          = 10'h000;
    flags        = '0;
    flags.result = file_val;
    case (op)
      op_add: begin
        sum          = add_carries(file_val, accum, 1'b0);
        flags.result = sum[7:0];
        flags.affect = 3'h7;
      end
      op_sub: begin
        sum          = add_carries(file_val, ~accum, 1'b1);
        flags.result = sum[7:0];
        flags.affect = 3'h7;
      end
      op_and: begin
        flags.result = file_val & accum;
        flags.affect = 3'h4;
      end
      op_or: begin
        flags.result = file_val | accum;
        flags.affect = 3'h4;
      end
      op_xor: begin
        flags.result = file_val ^ accum;
        flags.affect = 3'h4;
      end
      op_move:  flags.affect = 3'h4;
      op_clear: begin
        flags.result = 8'h00;
        flags.affect = 3'h4;
      end
      op_swap:      flags.result = {file_val[3:0], file_val[7:4]};
      op_store:     flags.result = accum;
      op_bit_clear: flags.result = file_val & ~(8'h01 << bit_idx);
      op_bit_set:   flags.result = file_val | (8'h01 << bit_idx);
      op_rot_right: begin
        flags.result = {carry_in, file_val[7:1]};
        sum[9]       = file_val[0];
        flags.affect = 3'h1;
      end
      op_rot_left: begin
        flags.result = {file_val[6:0], carry_in};
        sum[9]       = file_val[7];
        flags.affect = 3'h1;
      end
      default: flags.affect = 3'h0;
    endcase
    flags.zero         = (flags.result == 8'h00);
    flags.nibble_carry = sum[8];
    flags.carry        = sum[9];
  end
endmodule : cfsb_alu_flags
`default_nettype wire

// >>> cfsb_status_regions.sv
// status register, flag update and banked data memory decode
`default_nettype none
`include "cfsb_defs.svh"
module cfsb_status_regions #(
  parameter int GPR_BANKS = 1
) (
  // clock and resets
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       other_reset,
  // instruction from the execution path
  input  wire cfsb_pkg::cfsb_req_s        req,
  // hardware events
  input  wire logic                       watchdog_timeout,
  // read port
  input  wire logic                       rd_en,
  input  wire logic [`CFSB_PTR_W-1:0]     rd_addr,
  // read answer
  output logic [`CFSB_DATA_W-1:0]         rd_data_q,
  output cfsb_pkg::cfsb_region_e          rd_region_q,
  // status view
  output logic [`CFSB_DATA_W-1:0]         status_q,
  // accumulator result
  output logic [`CFSB_DATA_W-1:0]         accum_q,
  output logic                            accum_load_q,
  // writes to core and special-function registers outside this block
  output logic                            ext_wr_q,
  output logic [`CFSB_PTR_W-1:0]          ext_addr_q,
  output logic [`CFSB_DATA_W-1:0]         ext_data_q
);
  import cfsb_pkg::*;

  // ----------------------------------------------------------------
  // storage sizing
  // ----------------------------------------------------------------
  localparam int GPR_TOTAL = GPR_BANKS * int'(`CFSB_GPR_BYTES);
  localparam int IDX_W     = (GPR_TOTAL > 1) ? $clog2(GPR_TOTAL) : 1;

  // all block state in one record
  typedef struct packed {
    cfsb_status_s                                   st;
    logic [GPR_TOTAL-1:0][`CFSB_DATA_W-1:0]         general_purpose_ram;
    logic [`CFSB_COMMON_BYTES-1:0][`CFSB_DATA_W-1:0] common;
    logic [`CFSB_DATA_W-1:0]                        rd_data;
    cfsb_region_e                                   rd_region;
    logic [`CFSB_DATA_W-1:0]                        accum;
    logic                                           accum_load;
    logic                                           ext_wr;
    logic [`CFSB_PTR_W-1:0]                         ext_addr;
    logic [`CFSB_DATA_W-1:0]                        ext_data;
  } cfsb_state_s;

  cfsb_state_s   s_q;
  cfsb_state_s   s_d;
  cfsb_flags_s   alu;
  logic [7:0]    src_val;
  cfsb_region_e  wr_region;
  logic [IDX_W-1:0] wr_idx;
  logic [6:0]    wr_ofs;

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------

  // region of a 16-bit pointer; 12-bit banked space or linear window
  function automatic cfsb_region_e region_of(input logic [`CFSB_PTR_W-1:0] ptr);
    logic [15:0] lin;
    logic [6:0]  ofs;
    logic [4:0]  bank;
    lin  = ptr - `CFSB_LINEAR_BASE;
    ofs  = ptr[`CFSB_OFS_MSB:0];
    bank = ptr[`CFSB_BANK_MSB:`CFSB_BANK_LSB];
    if (ptr[15:13] == `CFSB_LINEAR_SEL) begin
      region_of = (32'(lin) < GPR_TOTAL) ? rgn_linear : rgn_unimpl;
    end else if (ptr[15:`CFSB_ADDR_W] != 4'h0) begin
      region_of = rgn_unimpl;
    end else if (ofs <= `CFSB_CORE_LAST) begin
      region_of = rgn_core;
    end else if (ofs <= `CFSB_SFR_LAST) begin
      region_of = rgn_sfr;
    end else if (ofs >= `CFSB_COMMON_FIRST) begin
      region_of = rgn_common;
    end else if (32'(bank) < GPR_BANKS) begin
      region_of = rgn_gpr;
    end else begin
      region_of = rgn_unimpl;
    end
  endfunction : region_of

  // storage index of a general-purpose byte, banked or linear
  function automatic logic [IDX_W-1:0] gpr_index(input logic [`CFSB_PTR_W-1:0] ptr);
    logic [15:0] t;
    if (ptr[15:13] == `CFSB_LINEAR_SEL) begin
      t = ptr - `CFSB_LINEAR_BASE;
    end else begin
      t = 16'(ptr[`CFSB_BANK_MSB:`CFSB_BANK_LSB]) * `CFSB_GPR_BYTES
          + 16'(ptr[`CFSB_OFS_MSB:0]) - 16'(`CFSB_GPR_FIRST);
    end
    return IDX_W'(t);
  endfunction : gpr_index

  // status byte as software sees it
  function automatic logic [7:0] status_byte(input cfsb_status_s st);
    return {`CFSB_UNIMPL_BITS, st};
  endfunction : status_byte

  // read one byte of the block's storage at a pointer
  function automatic logic [7:0] read_file(input cfsb_state_s s, input logic [`CFSB_PTR_W-1:0] ptr);
    cfsb_region_e r;
    r = region_of(ptr);
    if (r == rgn_core && ptr[`CFSB_OFS_MSB:0] == `CFSB_OFS_STATUS) begin
      read_file = status_byte(s.st);
    end else if (r == rgn_gpr || r == rgn_linear) begin
      read_file = s.general_purpose_ram[gpr_index(ptr)];
    end else if (r == rgn_common) begin
      read_file = s.common[ptr[3:0]];
    end else begin
      read_file = 8'h00;
    end
  endfunction : read_file

  // ----------------------------------------------------------------
  // alu
  // ----------------------------------------------------------------

  // source operand: literal or file contents before this instruction
  assign src_val   = req.use_literal ? req.literal : read_file(s_q, req.addr);
  assign wr_region = region_of(req.addr);
  assign wr_idx    = gpr_index(req.addr);
  assign wr_ofs    = req.addr[`CFSB_OFS_MSB:0];

  cfsb_alu_flags u_alu (
    .op       (req.op),
    .accum    (req.accum),
    .file_val (src_val),
    .bit_idx  (req.bit_idx),
    .carry_in (s_q.st.carry_flag),
    .flags    (alu)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // instruction effects, then hardware flags, then watchdog events
  always_comb begin
    s_d            = s_q;
    s_d.accum_load = 1'b0;
    s_d.ext_wr     = 1'b0;
    if (req.valid && !other_reset) begin
      case (req.op)
        op_watchdog_clear: begin
          s_d.st.watchdog_timeout_flag_n = 1'b1;
          s_d.st.powerdown_flag_n        = 1'b1;
        end
        op_sleep: begin
          s_d.st.watchdog_timeout_flag_n = 1'b1;
          s_d.st.powerdown_flag_n        = 1'b0;
        end
        op_none: begin
          s_d.st = s_q.st;
        end
        default: begin
          if (req.dest_file) begin
            // store the result where the address decodes
            if (wr_region == rgn_core && wr_ofs == `CFSB_OFS_STATUS) begin
              if (alu.affect == 3'h0) begin
                s_d.st.zero_flag         = alu.result[2];
                s_d.st.nibble_carry_flag = alu.result[1];
                s_d.st.carry_flag        = alu.result[0];
              end
              // top bits and timeout/powerdown never written by data
            end else if (wr_region == rgn_gpr || wr_region == rgn_linear) begin
              s_d.general_purpose_ram[wr_idx] = alu.result;
            end else if (wr_region == rgn_common) begin
              s_d.common[req.addr[3:0]] = alu.result;
            end else if (wr_region == rgn_core || wr_region == rgn_sfr) begin
              s_d.ext_wr   = 1'b1;
              s_d.ext_addr = req.addr;
              s_d.ext_data = alu.result;
            end
          end else begin
            s_d.accum      = alu.result;
            s_d.accum_load = 1'b1;
          end
          // hardware flags win; an op that affects any flag makes no data write to the status bits
          if (alu.affect[2]) begin
            s_d.st.zero_flag = alu.zero;
          end
          if (alu.affect[1]) begin
            s_d.st.nibble_carry_flag = alu.nibble_carry;
          end
          if (alu.affect[0]) begin
            s_d.st.carry_flag = alu.carry;
          end
        end
      endcase
    end
    // a time-out in the same cycle as a clear still clears the bit
    if (watchdog_timeout) begin
      s_d.st.watchdog_timeout_flag_n = 1'b0;
    end
    // read port returns contents before this cycle's write
    if (rd_en) begin
      s_d.rd_data   = read_file(s_q, rd_addr);
      s_d.rd_region = region_of(rd_addr);
    end
    if (other_reset) begin
      s_d.rd_data   = 8'h00;
      s_d.rd_region = rgn_unimpl;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // power-on/brown-out reset sets indicators and clears flags
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q                            <= '0;
      s_q.rd_region                  <= rgn_unimpl;
      s_q.st.watchdog_timeout_flag_n <= `CFSB_RST_TO_N;
      s_q.st.powerdown_flag_n        <= `CFSB_RST_PD_N;
      s_q.st.zero_flag               <= `CFSB_RST_ARITH;
      s_q.st.nibble_carry_flag       <= `CFSB_RST_ARITH;
      s_q.st.carry_flag              <= `CFSB_RST_ARITH;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // every output is a field of the state register
  assign rd_data_q    = s_q.rd_data;
  assign rd_region_q  = s_q.rd_region;
  assign status_q     = status_byte(s_q.st);
  assign accum_q      = s_q.accum;
  assign accum_load_q = s_q.accum_load;
  assign ext_wr_q     = s_q.ext_wr;
  assign ext_addr_q   = s_q.ext_addr;
  assign ext_data_q   = s_q.ext_data;
endmodule : cfsb_status_regions
`default_nettype wire

// >>> cfsb_status_sva.sv
// concurrent checks on the status flags and data memory region block ports
`default_nettype none
`include "cfsb_defs.svh"
module cfsb_status_sva #(
  parameter int GPR_BANKS = 1
) (
  // clock and resets
  input wire logic                    clock,
  input wire logic                    reset,
  input wire logic                    other_reset,
  // requests
  input wire cfsb_pkg::cfsb_req_s     req,
  input wire logic                    watchdog_timeout,
  input wire logic                    rd_en,
  input wire logic [`CFSB_PTR_W-1:0]  rd_addr,
  // answers
  input wire logic [`CFSB_DATA_W-1:0] rd_data_q,
  input wire cfsb_pkg::cfsb_region_e  rd_region_q,
  input wire logic [`CFSB_DATA_W-1:0] status_q,
  input wire logic [`CFSB_DATA_W-1:0] accum_q,
  input wire logic                    accum_load_q,
  input wire logic                    ext_wr_q,
  input wire logic [`CFSB_PTR_W-1:0]  ext_addr_q,
  input wire logic [`CFSB_DATA_W-1:0] ext_data_q
);
  import cfsb_pkg::*;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic       go;
  logic [8:0] sum_c;
  logic [4:0] nib_c;
  // accepted instruction and the literal-add reference sums
  assign go    = req.valid && !other_reset;
  assign sum_c = {1'b0, req.accum} + {1'b0, req.literal};
  assign nib_c = {1'b0, req.accum[3:0]} + {1'b0, req.literal[3:0]};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_top_bits_zero: assert property (status_q[7:5] == 3'h0)
    else $error("status top bits not zero");
  chk_timeout_clear: assert property (watchdog_timeout && !other_reset |=> !status_q[4])
    else $error("timeout bit not cleared");
  chk_sleep_bits: assert property (go && req.op == op_sleep && !watchdog_timeout |=> status_q[4:3] == 2'b10)
    else $error("sleep indicators wrong");
  chk_wdclr_bits: assert property (go && req.op == op_watchdog_clear && !watchdog_timeout |=> status_q[4:3] == 2'b11)
    else $error("watchdog clear indicators wrong");
  chk_indicator_hold: assert property (!watchdog_timeout && !(go && req.op inside {op_sleep, op_watchdog_clear})
    |=> $stable(status_q[4:3])) else $error("indicator changed by write");
  chk_clear_status: assert property (go && req.op == op_clear && req.addr == 16'h0003
    |=> status_q[2] && status_q[1:0] == $past(status_q[1:0])) else $error("clear status wrong");
  chk_store_status: assert property (go && req.op == op_store && req.dest_file && req.addr == 16'h0003
    |=> status_q[2:0] == $past(req.accum[2:0])) else $error("store to status wrong");
  chk_add_literal: assert property (go && req.op == op_add && req.use_literal && !req.dest_file
    |=> accum_load_q && accum_q == $past(sum_c[7:0]) && status_q[0] == $past(sum_c[8])
        && status_q[1] == $past(nib_c[4]) && status_q[2] == ($past(sum_c[7:0]) == 8'h00))
    else $error("literal add result or flags wrong");
  chk_other_reset: assert property (other_reset && !watchdog_timeout
    |=> $stable(status_q) && rd_data_q == 8'h00 && rd_region_q == rgn_unimpl) else $error("other reset wrong");
  chk_sfr_write: assert property (go && req.op == op_store && req.dest_file && req.addr == 16'h000C
    |=> ext_wr_q && ext_addr_q == 16'h000C && ext_data_q == $past(req.accum)) else $error("sfr write wrong");
  chk_status_read: assert property (rd_en && !other_reset && rd_addr == 16'h0003
    |=> rd_data_q == $past(status_q) && rd_region_q == rgn_core) else $error("status read wrong");
  chk_unimpl_read: assert property (rd_en && !other_reset && rd_addr[15:12] == 4'h1
    |=> rd_data_q == 8'h00 && rd_region_q == rgn_unimpl) else $error("unimplemented read wrong");
  // main scenarios reached
  cov_add_carry: cover property (go && req.op == op_add && sum_c[8]);
  cov_sleep: cover property (go && req.op == op_sleep);
  cov_other_reset: cover property (other_reset);
endmodule : cfsb_status_sva
`default_nettype wire

// >>> cfsb_exec_model.sv
// behavioural execution path issuing instructions and reads
`default_nettype none
`include "cfsb_defs.svh"
module cfsb_exec_model (
  // clock
  input  wire logic                    clock,
  // requests
  output var  cfsb_pkg::cfsb_req_s     req,
  output var  logic                    rd_en,
  output var  logic [`CFSB_PTR_W-1:0]  rd_addr,
  // read answer
  input  wire logic [`CFSB_DATA_W-1:0] rd_data_q,
  input  wire cfsb_pkg::cfsb_region_e  rd_region_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfsb_pkg::*;
  // ----------------------------------------
  // request lines idle at start
  // ----------------------------------------
  initial begin
    req = '0;
    rd_en = 1'b0;
    rd_addr = '0;
  end
  // one instruction held for one edge, then the fields are scrambled
  task automatic issue(input cfsb_op_e op, input logic [15:0] addr, input logic [7:0] acc,
                       input logic [7:0] lit, input logic use_lit, input logic dest,
                       input logic [2:0] bit_n = 3'h0);
    cfsb_req_s r;
    cfsb_req_s idle;
    r = '{valid: 1'b1, op: op, addr: addr, use_literal: use_lit, literal: lit, accum: acc,
          bit_idx: bit_n, dest_file: dest};
    idle = cfsb_req_s'(~r);
    idle.valid = 1'b0;
    @(posedge clock);
    req <= r;
    @(posedge clock);
    req <= idle;
    #1;
  endtask : issue
  // one read, answer taken after the edge that accepts it
  task automatic read(input logic [15:0] addr, output logic [7:0] data, output cfsb_region_e region);
    @(posedge clock);
    rd_en <= 1'b1;
    rd_addr <= addr;
    @(posedge clock);
    rd_en <= 1'b0;
    rd_addr <= ~addr;
    #1;
    data = rd_data_q;
    region = rd_region_q;
  endtask : read
endmodule : cfsb_exec_model
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the status flags and data memory region block
`default_nettype none
`include "cfsb_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cfsb_pkg::*;
  // ----------------------------------------
  // connections
  // ----------------------------------------
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic         other_reset = 1'b0;
  logic         watchdog_timeout = 1'b0;
  cfsb_req_s    req;
  logic         rd_en, accum_load_q, ext_wr_q;
  logic [15:0]  rd_addr, ext_addr_q;
  logic [7:0]   rd_data_q, status_q, accum_q, ext_data_q, data;
  cfsb_region_e rd_region_q, region;
  int           errors = 0;
  int           checks = 0;
  logic [15:0]  rd_tab [9] = '{16'h0003, 16'h000C, 16'h0020, 16'h0F70, 16'h0021, 16'h2000, 16'h2050, 16'h00A0, 16'h1003};
  logic [7:0]   dat_tab [9] = '{8'h18, 8'h00, 8'h01, 8'hA5, 8'h3C, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [5:0]   rgn_tab [9] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h08, 6'h20, 6'h01, 6'h01, 6'h01};
  // clock at 250 MHz
  always #2 clock = ~clock;
  cfsb_status_regions #(.GPR_BANKS(1)) dut (
    .clock(clock), .reset(reset), .other_reset(other_reset), .req(req), .watchdog_timeout(watchdog_timeout),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_region_q(rd_region_q), .status_q(status_q),
    .accum_q(accum_q), .accum_load_q(accum_load_q), .ext_wr_q(ext_wr_q), .ext_addr_q(ext_addr_q),
    .ext_data_q(ext_data_q));
  cfsb_exec_model bfm (
    .clock(clock), .req(req), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_region_q(rd_region_q));
  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // one pulse on a side input
  task automatic pulse(input int which);
    @(posedge clock);
    if (which == 0) begin
      watchdog_timeout <= 1'b1;
    end else begin
      other_reset <= 1'b1;
    end
    @(posedge clock);
    if (which == 0) begin
      watchdog_timeout <= 1'b0;
    end else begin
      other_reset <= 1'b0;
    end
    #1;
  endtask : pulse
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    check(status_q, 8'h18, "reset status");
    check({2'h0, rd_region_q}, 8'h01, "reset region");
    bfm.issue(op_add, 16'h0000, 8'h8F, 8'h71, 1'b1, 1'b0);
    check(accum_q, 8'h00, "add result");
    check({7'h0, accum_load_q}, 8'h01, "add load");
    check(status_q, 8'h1F, "add flags");
    bfm.issue(op_sub, 16'h0000, 8'h06, 8'h05, 1'b1, 1'b0);
    check(accum_q, 8'hFF, "sub borrow");
    check(status_q, 8'h18, "sub borrow flags");
    bfm.issue(op_sub, 16'h0000, 8'h01, 8'h10, 1'b1, 1'b0);
    check(status_q, 8'h19, "sub digit borrow");
    $display("test arith done");
    bfm.issue(op_store, 16'h0003, 8'hFF, 8'h00, 1'b0, 1'b1);
    check(status_q, 8'h1F, "store ones");
    bfm.issue(op_store, 16'h0003, 8'h00, 8'h00, 1'b0, 1'b1);
    check(status_q, 8'h18, "store zeros");
    bfm.issue(op_add, 16'h0003, 8'hE8, 8'h00, 1'b0, 1'b1);
    check(status_q, 8'h1F, "add into status");
    bfm.issue(op_store, 16'h0003, 8'h01, 8'h00, 1'b0, 1'b1);
    bfm.issue(op_clear, 16'h0003, 8'h00, 8'h00, 1'b0, 1'b1);
    check(status_q, 8'h1D, "clear status");
    $display("test status write done");
    bfm.issue(op_sleep, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0);
    check(status_q, 8'h15, "sleep");
    bfm.issue(op_watchdog_clear, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0);
    check(status_q, 8'h1D, "watchdog clear");
    pulse(0);
    check(status_q, 8'h0D, "timeout");
    bfm.issue(op_watchdog_clear, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0);
    $display("test indicators done");
    bfm.issue(op_store, 16'h0003, 8'h00, 8'h00, 1'b0, 1'b1);
    bfm.issue(op_store, 16'h0020, 8'h01, 8'h00, 1'b0, 1'b1);
    bfm.issue(op_rot_right, 16'h0020, 8'h00, 8'h00, 1'b0, 1'b0);
    check(accum_q, 8'h00, "rotate right");
    check(status_q, 8'h19, "rotate right carry");
    bfm.issue(op_rot_left, 16'h0020, 8'h00, 8'h00, 1'b0, 1'b0);
    check(accum_q, 8'h03, "rotate left");
    check(status_q, 8'h18, "rotate left carry");
    $display("test rotate done");
    bfm.issue(op_store, 16'h000C, 8'h5A, 8'h00, 1'b0, 1'b1);
    check({ext_wr_q, ext_addr_q[6:0]}, 8'h8C, "sfr write");
    check(ext_data_q, 8'h5A, "sfr data");
    bfm.issue(op_store, 16'h0070, 8'hA5, 8'h00, 1'b0, 1'b1);
    bfm.issue(op_store, 16'h2001, 8'h3C, 8'h00, 1'b0, 1'b1);
    foreach (rd_tab[i]) begin
      bfm.read(rd_tab[i], data, region);
      check(data, dat_tab[i], "read data");
      if (rgn_tab[i] != 6'h00) begin
        check({2'h0, region}, {2'h0, rgn_tab[i]}, "read region");
      end
    end
    $display("test regions done");
    bfm.issue(op_bit_set, 16'h0003, 8'h00, 8'h00, 1'b0, 1'b1, 3'h1);
    check(status_q, 8'h1A, "bit set status");
    bfm.issue(op_bit_clear, 16'h0003, 8'h00, 8'h00, 1'b0, 1'b1, 3'h4);
    check(status_q, 8'h1A, "bit clear timeout");
    bfm.issue(op_swap, 16'h0021, 8'h00, 8'h00, 1'b0, 1'b0);
    check(accum_q, 8'hC3, "swap result");
    check(status_q, 8'h1A, "swap flags");
    bfm.issue(op_xor, 16'h0021, 8'h3C, 8'h00, 1'b0, 1'b0);
    check(status_q, 8'h1E, "xor zero");
    bfm.issue(op_and, 16'h0021, 8'h0F, 8'h00, 1'b0, 1'b0);
    check(accum_q, 8'h0C, "and result");
    check(status_q, 8'h1A, "and nonzero");
    $display("test bit ops done");
    bfm.read(16'h0F70, data, region);
    pulse(1);
    check(status_q, 8'h1A, "other reset status");
    check(rd_data_q, 8'h00, "other reset data");
    bfm.issue(op_store, 16'h0003, 8'h07, 8'h00, 1'b0, 1'b1);
    bfm.issue(op_sleep, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0);
    check(status_q, 8'h17, "before reset");
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    #1;
    check(status_q, 8'h18, "power reset");
    $display("test resets done");
    test_done();
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    test_done();
  end
endmodule : testbench
bind cfsb_status_regions cfsb_status_sva #(.GPR_BANKS(GPR_BANKS)) u_sva (
  .clock(clock), .reset(reset), .other_reset(other_reset), .req(req), .watchdog_timeout(watchdog_timeout),
  .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_region_q(rd_region_q), .status_q(status_q),
  .accum_q(accum_q), .accum_load_q(accum_load_q), .ext_wr_q(ext_wr_q), .ext_addr_q(ext_addr_q),
  .ext_data_q(ext_data_q));
`default_nettype wire
